// ===== hdl/pbsp_pkg.sv
// Shared constants and types of the pipelined burst memory port
package pbsp_pkg;
    localparam int PBSP_ADDR_W = 20;
    localparam int PBSP_LANES = 2;
    localparam int PBSP_LANE_W = 9;
    localparam int PBSP_DATA_W = PBSP_LANES * PBSP_LANE_W;
    localparam int PBSP_CNT_W = 2;
    localparam int PBSP_WAKE_CYCLES = 2;
    localparam int PBSP_WBUF_DEPTH = 8;
    localparam logic [PBSP_CNT_W-1:0] PBSP_CNT_RST = 2'h0;
    localparam logic [1:0] PBSP_WAKE_RST = 2'h0;

    typedef enum logic [1:0] {
        PBSP_PWR_SLEEP,
        PBSP_PWR_WAKE,
        PBSP_PWR_RUN
    } pbsp_pwr_e;

    typedef struct packed {
        logic [PBSP_ADDR_W-1:0] addr;
        logic [PBSP_DATA_W-1:0] data;
        logic [PBSP_LANES-1:0] lanes;
    } pbsp_wreq_s;
endpackage : pbsp_pkg

// ===== hdl/pbsp_port.sv
// Burst memory port: array, burst counter, read pipeline, write buffer
`timescale 1ns/10ps

module pbsp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic mclk_i,              // System clock
    input wire logic srst_i,              // Synchronous reset
    input wire logic ce_i,                // Clock enable
    input wire logic in_valid_i,          // Word offered
    output logic in_ready_o,              // Room for a word
    input wire logic [WIDTH-1:0] in_data_i, // Word in
    output logic out_valid_o,             // Word available
    input wire logic out_ready_i,         // Drain accepts
    output logic [WIDTH-1:0] out_data_o   // Oldest word
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0] wp_r;
    logic [PW-1:0] rp_r;
    logic [PW:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready_o = (cnt_r != DEPTH[PW:0]);
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o = mem_r[rp_r];
    assign push = ce_i && in_valid_i && in_ready_o;
    assign pop = ce_i && out_valid_o && out_ready_i;

    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem_r[wp_r] <= in_data_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule : pbsp_fifo

module pbsp_port
    import pbsp_pkg::*;
#(
    parameter int WBUF_DEPTH = PBSP_WBUF_DEPTH
) (
    input wire logic mclk_i,                         // 50 MHz clock
    input wire logic srst_i,                         // Sync reset, high
    input wire logic ce_i,                           // Clock enable
    input wire logic [PBSP_ADDR_W-1:0] addr_i,       // External address
    input wire logic proc_addr_strobe_n_i,           // Processor strobe
    input wire logic ctrl_addr_strobe_n_i,           // Controller strobe
    input wire logic burst_step_n_i,                 // Burst advance
    input wire logic select_one_n_i,                 // First select
    input wire logic select_two_i,                   // Second select
    input wire logic select_three_n_i,               // Third select
    input wire logic [PBSP_LANES-1:0] lane_write_n_i, // Lane enables
    input wire logic full_write_n_i,                 // Full write
    input wire logic lane_write_gate_n_i,            // Lane gate
    input wire logic out_enable_n_i,                 // Async output enable
    input wire logic burst_order_sel_i,              // Static burst order
    input wire logic sleep_request_i,                // Async sleep pin
    input wire logic [PBSP_DATA_W-1:0] dq_i,         // Data pins in
    output logic [PBSP_DATA_W-1:0] dq_o,             // Data pins out
    output logic dq_oe_n_o,                          // Data drive, low drives
    output logic wbuf_ready_o                        // Write buffer room
);
    logic [PBSP_DATA_W-1:0] mem [2**PBSP_ADDR_W];
    logic slp_m_r;
    logic slp_s_r;
    pbsp_pwr_e pwr_r;
    logic [1:0] wake_r;
    logic awake;
    logic run;
    logic selected;
    logic p_start;
    logic c_start;
    logic cont;
    logic [PBSP_LANES-1:0] lanes;
    logic wr;
    logic act_r;
    logic [PBSP_ADDR_W-1:0] base_r;
    logic [PBSP_CNT_W-1:0] cnt_r;
    logic [PBSP_CNT_W-1:0] cnt_nxt;
    logic [PBSP_CNT_W-1:0] lsb;
    logic [PBSP_ADDR_W-1:0] addr_r;
    logic [PBSP_ADDR_W-1:0] addr_nxt;
    logic rd_iss;
    logic wr_iss;
    logic rd_r;
    logic vld1_r;
    logic vld2_r;
    logic [PBSP_DATA_W-1:0] dout_r;
    logic [PBSP_DATA_W-1:0] obuf_r;
    logic drv_r;
    pbsp_wreq_s wreq;
    pbsp_wreq_s wq;
    logic wq_valid;
    logic wq_ready;

    // Undriven sleep safe
    // Pad pull-down keeps the pin low; synchroniser resets to awake side
    // Sleep synchroniser
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            slp_m_r <= 1'b0;
            slp_s_r <= 1'b0;
        end else if (ce_i) begin
            slp_m_r <= sleep_request_i;
            slp_s_r <= slp_m_r;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            pwr_r <= PBSP_PWR_RUN;
            wake_r <= PBSP_WAKE_RST;
        end else if (ce_i) begin
            unique case (pwr_r)
                PBSP_PWR_RUN: begin
                    if (slp_s_r) begin
                        pwr_r <= PBSP_PWR_SLEEP;
                    end
                end
                PBSP_PWR_SLEEP: begin
                    wake_r <= PBSP_WAKE_RST;
                    if (!slp_s_r) begin
                        pwr_r <= PBSP_PWR_WAKE;
                    end
                end
                PBSP_PWR_WAKE: begin
                    wake_r <= wake_r + 2'h1;
                    if (slp_s_r) begin
                        pwr_r <= PBSP_PWR_SLEEP;
                    end else if (wake_r == 2'(PBSP_WAKE_CYCLES - 1)) begin
                        pwr_r <= PBSP_PWR_RUN;
                    end
                end
            endcase
        end
    end

    assign awake = (pwr_r == PBSP_PWR_RUN) && !slp_s_r;
    assign run = ce_i && awake;

    assign selected = !select_one_n_i && select_two_i && !select_three_n_i;
    assign p_start = !proc_addr_strobe_n_i && !select_one_n_i;
    // Controller start needs no processor start: processor strobe high or first select high
    assign c_start = !p_start && !ctrl_addr_strobe_n_i;
    assign cont = !p_start && !c_start && act_r;

    assign lanes = !full_write_n_i ? '1 :
                   (!lane_write_gate_n_i ? ~lane_write_n_i : '0);
    assign wr = !p_start && (lanes != '0);

    // Interleaved or linear order
    // Built from cnt_r, not cnt_nxt, to keep the next-state logic loop free
    assign lsb = burst_order_sel_i ? (base_r[PBSP_CNT_W-1:0] ^ (cnt_r + 2'h1))
                                   : (base_r[PBSP_CNT_W-1:0] + cnt_r + 2'h1);

    always_comb begin
        cnt_nxt = cnt_r;
        addr_nxt = addr_r;
        rd_iss = 1'b0;
        wr_iss = 1'b0;
        if ((p_start || c_start) && selected) begin
            cnt_nxt = PBSP_CNT_RST;
            addr_nxt = addr_i;
            wr_iss = c_start && wr;
            rd_iss = !wr_iss;
        end else if (cont) begin
            if (!burst_step_n_i) begin
                cnt_nxt = cnt_r + 2'h1;
                addr_nxt = {base_r[PBSP_ADDR_W-1:PBSP_CNT_W], lsb};
            end
            wr_iss = wr;
            rd_iss = !wr;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            act_r <= 1'b0;
            base_r <= '0;
            cnt_r <= PBSP_CNT_RST;
            addr_r <= '0;
        end else if (run) begin
            cnt_r <= cnt_nxt;
            addr_r <= addr_nxt;
            if (p_start || c_start) begin
                act_r <= selected;
                base_r <= addr_i;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            rd_r <= 1'b0;
            vld1_r <= 1'b0;
            vld2_r <= 1'b0;
            dout_r <= '0;
            obuf_r <= '0;
        end else if (run) begin
            rd_r <= rd_iss;
            vld1_r <= rd_r;
            vld2_r <= vld1_r;
            dout_r <= mem[addr_r];
            obuf_r <= dout_r;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            drv_r <= 1'b0;
        end else if (run) begin
            drv_r <= vld1_r && (lane_write_n_i == '1) && !wr_iss;
        end
    end

    assign wreq.addr = addr_nxt;
    assign wreq.data = dq_i;
    assign wreq.lanes = lanes;

    // Buffer drains one word per awake cycle, so it fills only if stalled
    pbsp_fifo #(
        .WIDTH($bits(pbsp_wreq_s)),
        .DEPTH(WBUF_DEPTH)
    ) u_wbuf (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .in_valid_i(run && wr_iss),
        .in_ready_o(wbuf_ready_o),
        .in_data_i(wreq),
        .out_valid_o(wq_valid),
        .out_ready_i(awake),
        .out_data_o(wq)
    );
    assign wq_ready = awake;

    always_ff @(posedge mclk_i) begin
        if (ce_i && wq_valid && wq_ready) begin
            for (int i = 0; i < PBSP_LANES; i++) begin
                if (wq.lanes[i]) begin
                    mem[wq.addr][i*PBSP_LANE_W +: PBSP_LANE_W] <=
                        wq.data[i*PBSP_LANE_W +: PBSP_LANE_W];
                end
            end
        end
    end

    assign dq_o = obuf_r;
    // Enable and sleep act without the clock
    assign dq_oe_n_o = !(drv_r && !out_enable_n_i && !sleep_request_i);

    property p_wake;
        @(posedge mclk_i) disable iff (srst_i || !ce_i)
        (pwr_r == PBSP_PWR_SLEEP && !slp_s_r) |=> !awake ##1 !awake;
    endproperty
    a_wake: assert property (p_wake) else $error("woke too early");

    property p_freeze;
        @(posedge mclk_i) disable iff (srst_i)
        slp_s_r |=> $stable(addr_r) && $stable(cnt_r) && $stable(obuf_r);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved in sleep");

    property p_load;
        @(posedge mclk_i) disable iff (srst_i)
        (run && p_start && selected) |=> addr_r == $past(addr_i) && cnt_r == 2'h0;
    endproperty
    a_load: assert property (p_load) else $error("start address not loaded");

    property p_pipe;
        @(posedge mclk_i) disable iff (srst_i || !ce_i || !awake)
        (run && rd_iss) |=> rd_r ##1 vld1_r ##1 vld2_r;
    endproperty
    a_pipe: assert property (p_pipe) else $error("read pipe depth wrong");

    property p_block;
        @(posedge mclk_i) disable iff (srst_i)
        (run && select_one_n_i && ctrl_addr_strobe_n_i && !act_r) |=> !act_r;
    endproperty
    a_block: assert property (p_block) else $error("strobe not blocked");

    property p_allmask;
        @(posedge mclk_i) disable iff (srst_i)
        (run && wr_iss && !full_write_n_i) |-> wreq.lanes == '1;
    endproperty
    a_allmask: assert property (p_allmask) else $error("full write lost lanes");

    property p_drvoff;
        @(posedge mclk_i) disable iff (srst_i)
        (run && lane_write_n_i != '1) |=> dq_oe_n_o;
    endproperty
    a_drvoff: assert property (p_drvoff) else $error("drove during write");

    property p_step;
        @(posedge mclk_i) disable iff (srst_i)
        (run && cont && !burst_step_n_i) |=> cnt_r == $past(cnt_r) + 2'h1;
    endproperty
    a_step: assert property (p_step) else $error("burst did not step");

    property p_hold;
        @(posedge mclk_i) disable iff (srst_i)
        (run && cont && burst_step_n_i) |=> $stable(addr_r) && $stable(cnt_r);
    endproperty
    a_hold: assert property (p_hold) else $error("wait state moved address");

    property p_seq;
        @(posedge mclk_i) disable iff (srst_i)
        (run && cont && !burst_step_n_i) |=> addr_r[1:0] == (burst_order_sel_i ?
            (base_r[1:0] ^ cnt_r) : (base_r[1:0] + cnt_r));
    endproperty
    a_seq: assert property (p_seq) else $error("burst order wrong");
endmodule : pbsp_port

// ===== tb/pbsp_host_model.sv
// Host model: processor or cache controller driving the burst port
`timescale 1ns/10ps

module pbsp_host_model
    import pbsp_pkg::*;
(
    input wire logic mclk_i, // Clock
    input wire logic [PBSP_DATA_W-1:0] rd_data_i, // Device data
    input wire logic rd_oe_n_i, // Device drives when low
    output logic [PBSP_DATA_W-1:0] wr_data_o, // Wire level
    output logic [PBSP_ADDR_W-1:0] addr_o, // Address
    output logic proc_n_o, // Processor strobe
    output logic ctrl_n_o, // Controller strobe
    output logic step_n_o, // Burst advance
    output logic [2:0] sel_o, // Selects one, two, three
    output logic [PBSP_LANES-1:0] lane_n_o, // Lane enables
    output logic full_n_o, // Full write
    output logic gate_n_o, // Lane gate
    output logic oe_n_o, // Output enable
    output logic sleep_o // Sleep request
);
    logic [PBSP_DATA_W-1:0] drv_q;
    logic [PBSP_DATA_W-1:0] last_q;
    logic oe_hold;

    // Released bus keeps toggling so a stale value never passes
    assign wr_data_o = !rd_oe_n_i ? rd_data_i :
                       ((lane_n_o != 2'h3 || !full_n_o) ? drv_q : ~last_q);

    always @(posedge mclk_i) begin
        last_q <= wr_data_o;
    end

    initial begin
        {proc_n_o, ctrl_n_o, step_n_o} = 3'h7;
        sel_o = 3'h2;
        lane_n_o = 2'h3;
        {full_n_o, gate_n_o, oe_n_o, oe_hold} = 4'h8;
        sleep_o = 1'b0;
        addr_o = 20'h0;
        drv_q = 18'h0;
        last_q = 18'h0;
    end

    task automatic cyc(input logic p, input logic c, input logic s, input logic [1:0] wl,
                       input logic [19:0] a, input logic [17:0] d);
        proc_n_o = p | !c;
        ctrl_n_o = c;
        step_n_o = s;
        lane_n_o = wl;
        oe_n_o = oe_hold | (wl != 2'h3) | !full_n_o;
        addr_o = a;
        drv_q = d;
        @(negedge mclk_i);
    endtask : cyc

    task automatic mode(input logic f, input logic g);
        full_n_o = f;
        gate_n_o = g;
    endtask : mode

    task automatic set_oe(input logic v);
        oe_hold = v;
        oe_n_o = v;
    endtask : set_oe

    task automatic nap(input logic on);
        sleep_o = on;
        if (!on) repeat (PBSP_WAKE_CYCLES + 4) @(negedge mclk_i);
    endtask : nap
endmodule : pbsp_host_model

// ===== tb/test_pipelined_burst_sram_port.sv
// Self-checking bench of the pipelined burst memory port
`timescale 1ns/10ps

module test_pipelined_burst_sram_port
    import pbsp_pkg::*;
;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic ord = 1'b0;
    logic ce = 1'b1;
    logic [17:0] wire_q, rd_q;
    logic [19:0] addr;
    logic [2:0] sel;
    logic [1:0] lane_n;
    logic proc_n, ctrl_n, step_n, full_n, gate_n, oe_in_n, sleep, oe_n, wb_rdy;
    logic [17:0] mem[logic [19:0]];
    int error_cnt = 0;
    int comparisons = 0;
    int cycles = 0;

    always #10 mclk = ~mclk;

    pbsp_port #(.WBUF_DEPTH(8)) dut_u (
        .mclk_i(mclk), .srst_i(srst), .ce_i(ce), .addr_i(addr),
        .proc_addr_strobe_n_i(proc_n), .ctrl_addr_strobe_n_i(ctrl_n),
        .burst_step_n_i(step_n), .select_one_n_i(sel[2]), .select_two_i(sel[1]),
        .select_three_n_i(sel[0]), .lane_write_n_i(lane_n), .full_write_n_i(full_n),
        .lane_write_gate_n_i(gate_n), .out_enable_n_i(oe_in_n),
        .burst_order_sel_i(ord), .sleep_request_i(sleep), .dq_i(wire_q),
        .dq_o(rd_q), .dq_oe_n_o(oe_n), .wbuf_ready_o(wb_rdy)
    );

    pbsp_host_model h (
        .mclk_i(mclk), .rd_data_i(rd_q), .rd_oe_n_i(oe_n), .wr_data_o(wire_q),
        .addr_o(addr), .proc_n_o(proc_n), .ctrl_n_o(ctrl_n), .step_n_o(step_n),
        .sel_o(sel), .lane_n_o(lane_n), .full_n_o(full_n), .gate_n_o(gate_n),
        .oe_n_o(oe_in_n), .sleep_o(sleep)
    );

    task automatic close_out();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, want, seen);
        end
    endtask : check

    task automatic idle(input int n);
        repeat (n) h.cyc(1'b1, 1'b1, 1'b1, 2'h3, 20'h0, 18'h0);
    endtask : idle

    function automatic logic [19:0] beat(input logic [19:0] a, input logic [1:0] n);
        return {a[19:2], ord ? a[1:0] ^ n : a[1:0] + n};
    endfunction : beat

    // Read burst; advn gives advance level at edges one to five
    task automatic rd_burst(input logic [19:0] a, input logic [4:0] advn);
        logic [1:0] n;
        logic [19:0] q[6];
        n = 2'h0;
        q[0] = a;
        h.cyc(1'b0, 1'b1, 1'b0, 2'h0, a, 18'h0);
        for (int k = 1; k < 6; k++) begin
            n = n + {1'b0, ~advn[k-1]};
            q[k] = beat(a, n);
            h.cyc(1'b1, 1'b1, advn[k-1], 2'h3, a, 18'h0);
            if (k >= 2) check("read data", rd_q, mem[q[k-2]]);
            if (k == 2) check("read drive", oe_n, 1'b0);
        end
    endtask : rd_burst

    // Four-beat write started by the controller strobe
    task automatic wr_burst(input logic [19:0] a, input logic [17:0] d);
        for (int k = 0; k < 4; k++) begin
            mem[beat(a, k[1:0])] = d + 18'(k);
            h.cyc(1'b1, k != 0, k == 0, 2'h0, a, d + 18'(k));
        end
        idle(1);
    endtask : wr_burst

    task automatic s_linear();
        ord = 1'b0;
        wr_burst(20'h00012, 18'h0a000);
        check("buffer room", wb_rdy, 1'b1);
        rd_burst(20'h00013, 5'h18);
        rd_burst(20'h00010, 5'h19);
    endtask : s_linear

    task automatic s_inter();
        ord = 1'b1;
        wr_burst(20'h00022, 18'h0b000);
        rd_burst(20'h00021, 5'h18);
        ord = 1'b0;
        rd_burst(20'h00020, 5'h18);
    endtask : s_inter

    task automatic s_lane();
        wr_burst(20'h00040, 18'h00100);
        h.mode(1'b1, 1'b0);
        h.cyc(1'b1, 1'b0, 1'b1, 2'h2, 20'h00040, 18'h3ffff);
        mem[20'h00040][8:0] = 9'h1ff;
        h.mode(1'b1, 1'b1);
        h.cyc(1'b1, 1'b0, 1'b1, 2'h0, 20'h00041, 18'h3ffff);
        h.mode(1'b0, 1'b1);
        mem[20'h00042] = 18'h2aaaa;
        h.cyc(1'b1, 1'b0, 1'b1, 2'h3, 20'h00042, 18'h2aaaa);
        h.mode(1'b1, 1'b0);
        idle(1);
        rd_burst(20'h00040, 5'h18);
    endtask : s_lane

    task automatic s_select();
        logic [2:0] c[3];
        c = '{3'h6, 3'h0, 3'h3};
        rd_burst(20'h00010, 5'h18);
        h.set_oe(1'b1);
        idle(1);
        check("oe off", oe_n, 1'b1);
        h.set_oe(1'b0);
        idle(1);
        check("oe on", oe_n, 1'b0);
        foreach (c[i]) begin
            h.sel_o = c[i];
            h.cyc(1'b0, 1'b1, 1'b1, 2'h3, 20'h00010, 18'h0);
            idle(3);
            // First pass: strobe blocked, suspended burst keeps going
            if (i == 0) check("blocked", rd_q, mem[20'h00013]);
            check("deselect", oe_n, i != 0);
        end
        h.sel_o = 3'h2;
    endtask : s_select

    task automatic s_sleep();
        h.nap(1'b1);
        idle(4);
        check("sleep drive", oe_n, 1'b1);
        h.cyc(1'b1, 1'b0, 1'b1, 2'h0, 20'h00010, 18'h15555);
        idle(1);
        h.nap(1'b0);
        rd_burst(20'h00010, 5'h18);
        ce = 1'b0;
        h.cyc(1'b0, 1'b1, 1'b1, 2'h3, 20'h00020, 18'h0);
        idle(2);
        ce = 1'b1;
        check("frozen", rd_q, mem[20'h00013]);
    endtask : s_sleep

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 1500) begin
            error_cnt++;
            close_out();
        end
    end

    initial begin
        repeat (20) @(negedge mclk);
        srst = 1'b0;
        s_linear();
        s_inter();
        s_lane();
        s_select();
        s_sleep();
        close_out();
    end
endmodule : test_pipelined_burst_sram_port
